/* File: design/scmc_pkg.sv */
// Package: offsets, bit positions, reset values and timing of the block.
// Assumes a byte-wide register port decoded from the serial interface.
package scmc_pkg;

   // ===
   // Register byte addresses (low byte)
   localparam logic [5:0] OFS_DAC = 6'h30;
   localparam logic [5:0] OFS_OFFSET = 6'h32;
   localparam logic [5:0] OFS_MSC = 6'h34;
   localparam logic [5:0] OFS_SMPL = 6'h36;
   localparam logic [5:0] OFS_STATUS = 6'h3C;
   localparam logic [5:0] OFS_CMD = 6'h3E;

   // ===
   // Status flag positions
   localparam int ST_SUP_LOW = 0;
   localparam int ST_SUP_HIGH = 1;
   localparam int ST_UPD_FAIL = 2;
   localparam int ST_SPI_FAIL = 3;
   localparam int ST_SELF_FAIL = 5;
   localparam int ST_ALM1 = 8;
   localparam int ST_ALM2 = 9;

   // ===
   // Command bit positions
   localparam int CMD_ZERO = 0;
   localparam int CMD_FACTORY = 1;
   localparam int CMD_DAC = 2;
   localparam int CMD_STORE = 3;
   localparam int CMD_CLR = 4;
   localparam int CMD_SOFT_RST = 7;

   // ===
   // Misc-control bits and write masks
   localparam int MSC_DR_SEL = 0;
   localparam int MSC_DR_POL = 1;
   localparam int MSC_DR_EN = 2;
   localparam int MSC_SELF_EN = 8;
   localparam int MSC_REV = 9;
   localparam int MSC_NO_PST = 10;
   localparam logic [15:0] MSC_WMASK = 16'h0707;
   localparam logic [15:0] SMPL_WMASK = 16'h00FF;
   localparam logic [15:0] DAC_WMASK = 16'h0FFF;

   // ===
   // Reset values and the self-test sample period
   localparam logic [15:0] RST_STATUS = 16'h0000;
   localparam logic [15:0] RST_MSC = 16'h0000;
   localparam logic [15:0] RST_SMPL = 16'h0008;
   localparam logic [15:0] RST_OFFSET = 16'h0000;
   localparam logic [15:0] RST_DAC = 16'h0000;
   localparam logic [15:0] SMPL_FAST = 16'h0001;

   // ===
   // Angle codes, 0.025 degree per step
   localparam logic [13:0] ANGLE_FULL = 14'h3840;
   localparam logic [13:0] ANGLE_HALF = 14'h1C20;
   localparam logic [13:0] ANGLE_SELF = 14'h05C8;

   // ===
   // Nonvolatile image entries
   localparam logic [1:0] NV_MSC = 2'h0;
   localparam logic [1:0] NV_SMPL = 2'h1;
   localparam logic [1:0] NV_OFFSET = 2'h2;
   localparam logic [1:0] NV_LAST = 2'h2;

   // ===
   // Timing
   localparam int CLK_MHZ = 200;
   localparam int FLASH_TIME_MS = 50;
   localparam int FLASH_CYCLES = FLASH_TIME_MS * CLK_MHZ * 1000;

   typedef enum logic [1:0] {NV_IDLE, NV_WRITE, NV_WAIT, NV_LOAD} nv_state_e;

endpackage

/* File: design/nv_image_mem.sv */
// Small memory holding the nonvolatile register image.
// Assumes one write or one read per cycle; read data come from a register.
`timescale 1ns/100ps
module nv_image_mem
(
   // Clock
   input wire logic clk,
   // Access
   input wire logic wr_en,
   input wire logic [1:0] addr,
   input wire logic [15:0] wr_data,
   output logic [15:0] rd_data
);
   logic [15:0] mem_ff [0:3];
   logic [15:0] rd_data_ff;

   // ===
   // Storage and registered read
   always_ff @(posedge clk)
   begin
      if (wr_en)
      begin
         mem_ff[addr] <= wr_data;
      end
      rd_data_ff <= mem_ff[addr];
   end

   assign rd_data = rd_data_ff;
endmodule

/* File: design/status_command_misc_control.sv */
// Status flags, global commands and miscellaneous control of a tilt sensor.
// Assumes a byte register port from the serial front end, synchronous inputs.
// Function
// - Status word is read-only, resets to zero, writes ignored.
// - Each flag is set again every cycle while its condition persists.
// - Supply flags at bits 0 and 1 clear themselves when supply is in range.
// - Bit 1 flags supply above 3.625 V, bit 0 below 2.975 V.
// - Bit 3 flags serial failure, bit 2 flags failed control update.
// - Output words carry alarm in bit 14; bits 9 and 8 show alarms.
// - Bit 5 reports self-test failure as one, pass as zero.
// - Write-only command word; ones launch reset, clear, store, latch, factory, zero.
// - Each write of command bit 4 clears once all status flags whose condition is absent in that cycle.
// - Store copies nonvolatile registers to flash; host keeps quiet 50 ms.
// - DAC takes new data only on the latch command.
// - Factory reset zeroes tilt offset, clears filters, then stores to flash.
// - Zeroing loads offset making both outputs zero, then stores to flash.
// - Enabled data-ready drives the selected general-purpose pin after processing.
// - Data-ready goes active on processing done, inactive midway next conversion.
// - Pin priority: misc control over alarm control over pin control.
// - During self-test the inclination outputs show nominal 37 degrees.
// - Self-test forces a fast sample period, restoring the original afterwards.
// - Misc bit 2 enables data-ready, bit 1 active-high, bit 0 second line.
// - Misc bit 9 reverses rotation of both inclination outputs.
`timescale 1ns/100ps
module status_command_misc_control
#(
   parameter int FLASH_WAIT = scmc_pkg::FLASH_CYCLES
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register port
   input wire logic reg_wr_en,
   input wire logic [5:0] reg_wr_addr,
   input wire logic [7:0] reg_wr_data,
   input wire logic reg_rd_en,
   input wire logic [5:0] reg_rd_addr,
   output logic [15:0] reg_rd_data,
   // Condition inputs
   input wire logic supply_low,
   input wire logic supply_high,
   input wire logic spi_fail,
   input wire logic alarm1_active,
   input wire logic alarm2_active,
   input wire logic self_check_fail,
   // Conversion timing
   input wire logic proc_done,
   input wire logic conv_midway,
   // Angle path
   input wire logic [13:0] incl_raw,
   output logic [15:0] incl_word,
   output logic [15:0] incl180_word,
   // Side effects
   output logic [15:0] sample_period_reg,
   output logic [11:0] dac_code,
   output logic filter_clear,
   output logic flash_busy,
   // Pin claims from alarm control and pin control
   input wire logic [1:0] alm_pin_claim,
   input wire logic [1:0] alm_pin_level,
   input wire logic [1:0] gpio_dir,
   input wire logic [1:0] gpio_level,
   // General-purpose pins
   output logic io_line_first_out,
   output logic io_line_first_oe,
   output logic io_line_second_out,
   output logic io_line_second_oe
);
   import scmc_pkg::*;

   logic [1:0] rst_sync_ff;
   logic rst_s_n;
   logic [7:0] cmd_ff;
   logic [15:0] status_ff;
   logic [15:0] nxt_status;
   logic [15:0] misc_control_reg_ff;
   logic [15:0] smpl_ff;
   logic [15:0] smpl_saved_ff;
   logic [15:0] tilt_offset_reg_ff;
   logic [15:0] dac_data_ff;
   logic [11:0] dac_code_ff;
   logic self_run_ff;
   logic dr_active_ff;
   logic filter_clear_ff;
   logic [15:0] rd_data_ff;
   logic [15:0] incl_word_ff;
   logic [15:0] incl180_word_ff;
   logic [1:0] io_out_ff;
   logic [1:0] io_oe_ff;
   nv_state_e nv_state_ff;
   logic [1:0] nv_idx_ff;
   logic [23:0] wait_cnt_ff;
   logic image_valid_ff;
   logic flash_busy_ff;
   logic load_vld_ff;
   logic [1:0] load_idx_ff;
   logic [15:0] mem_rd;
   logic [15:0] mem_wdata;
   logic mem_wr;
   logic soft_rst;
   logic store_req;
   logic nv_busy;
   logic upd_fail;
   logic [13:0] angle_diff;
   logic [13:0] angle_corr;
   logic [13:0] angle_show;
   logic dr_level;

   // ===
   // Reset release through two flip-flops
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_sync_ff <= 2'h0;
      end
      else
      begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_s_n = rst_sync_ff[1];

   // Merge one byte under a writable mask
   function automatic logic [15:0] merge_byte(input logic [15:0] old, input logic hi,
                                              input logic [7:0] data,
                                              input logic [15:0] mask);
      logic [15:0] nv;
      nv = hi ? {data, old[7:0]} : {old[15:8], data};
      return (nv & mask) | (old & ~mask);
   endfunction

   // ===
   // Command pulses, one cycle each
   always_ff @(posedge clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
      begin
         cmd_ff <= 8'h00;
      end
      else if (reg_wr_en && reg_wr_addr == OFS_CMD)
      begin
         cmd_ff <= reg_wr_data;
      end
      else
      begin
         cmd_ff <= 8'h00;
      end
   end
   assign soft_rst = cmd_ff[CMD_SOFT_RST];
   assign store_req = cmd_ff[CMD_STORE] | cmd_ff[CMD_FACTORY] | cmd_ff[CMD_ZERO];
   assign nv_busy = (nv_state_ff != NV_IDLE);

   // Update failure: store or NV write while busy
   assign upd_fail = (store_req && nv_busy) ||
                     (reg_wr_en && nv_busy && reg_wr_addr[5:1] >= OFS_OFFSET[5:1] &&
                      reg_wr_addr[5:1] <= OFS_SMPL[5:1]);

   // ===
   // Status flags; a set in the clearing cycle wins
   always_comb
   begin
      nxt_status = status_ff;
      if (cmd_ff[CMD_CLR] || soft_rst)
      begin
         nxt_status = RST_STATUS;
      end
      if (spi_fail)
      begin
         nxt_status[ST_SPI_FAIL] = 1'b1;
      end
      if (upd_fail)
      begin
         nxt_status[ST_UPD_FAIL] = 1'b1;
      end
      if (self_run_ff && self_check_fail)
      begin
         nxt_status[ST_SELF_FAIL] = 1'b1;
      end
      if (alarm1_active)
      begin
         nxt_status[ST_ALM1] = 1'b1;
      end
      if (alarm2_active)
      begin
         nxt_status[ST_ALM2] = 1'b1;
      end
      // Supply flags follow the comparators directly
      nxt_status[ST_SUP_LOW] = supply_low;
      nxt_status[ST_SUP_HIGH] = supply_high;
   end

   // Status register: no write path reaches it
   always_ff @(posedge clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
      begin
         status_ff <= RST_STATUS;
      end
      else
      begin
         status_ff <= nxt_status;
      end
   end

   // ===
   // Misc control; self-test bit is volatile
   always_ff @(posedge clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
      begin
         misc_control_reg_ff <= RST_MSC;
      end
      else if (soft_rst)
      begin
         misc_control_reg_ff <= RST_MSC;
      end
      else if (load_vld_ff && load_idx_ff == NV_MSC)
      begin
         misc_control_reg_ff <= mem_rd & MSC_WMASK & ~(16'h0001 << MSC_SELF_EN);
      end
      else if (reg_wr_en && !nv_busy && reg_wr_addr[5:1] == OFS_MSC[5:1])
      begin
         misc_control_reg_ff <= merge_byte(misc_control_reg_ff, reg_wr_addr[0],
                                           reg_wr_data, MSC_WMASK);
      end
   end

   // ===
   // Sample period with self-test swap and restore
   always_ff @(posedge clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
      begin
         smpl_ff <= RST_SMPL;
         smpl_saved_ff <= RST_SMPL;
         self_run_ff <= 1'b0;
      end
      else if (soft_rst)
      begin
         smpl_ff <= self_run_ff ? smpl_saved_ff : smpl_ff;
         self_run_ff <= 1'b0;
      end
      else if (misc_control_reg_ff[MSC_SELF_EN] && !self_run_ff)
      begin
         smpl_saved_ff <= smpl_ff;
         smpl_ff <= SMPL_FAST;
         self_run_ff <= 1'b1;
      end
      else if (!misc_control_reg_ff[MSC_SELF_EN] && self_run_ff)
      begin
         smpl_ff <= smpl_saved_ff;
         self_run_ff <= 1'b0;
      end
      else if (load_vld_ff && load_idx_ff == NV_SMPL)
      begin
         smpl_ff <= mem_rd & SMPL_WMASK;
      end
      else if (reg_wr_en && !nv_busy && !self_run_ff &&
               reg_wr_addr[5:1] == OFS_SMPL[5:1])
      begin
         smpl_ff <= merge_byte(smpl_ff, reg_wr_addr[0], reg_wr_data, SMPL_WMASK);
      end
   end

   // ===
   // Tilt offset: host write, factory reset, zeroing, image reload
   always_ff @(posedge clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
      begin
         tilt_offset_reg_ff <= RST_OFFSET;
      end
      else if (soft_rst || (cmd_ff[CMD_FACTORY] && !nv_busy))
      begin
         tilt_offset_reg_ff <= RST_OFFSET;
      end
      else if (cmd_ff[CMD_ZERO] && !nv_busy)
      begin
         tilt_offset_reg_ff <= {2'h0, incl_raw};
      end
      else if (load_vld_ff && load_idx_ff == NV_OFFSET)
      begin
         tilt_offset_reg_ff <= mem_rd;
      end
      else if (reg_wr_en && !nv_busy && reg_wr_addr[5:1] == OFS_OFFSET[5:1])
      begin
         tilt_offset_reg_ff <= merge_byte(tilt_offset_reg_ff, reg_wr_addr[0],
                                          reg_wr_data, 16'h3FFF);
      end
   end

   // ===
   // DAC data bytes and latched code
   always_ff @(posedge clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
      begin
         dac_data_ff <= RST_DAC;
         dac_code_ff <= 12'h000;
         filter_clear_ff <= 1'b0;
      end
      else
      begin
         if (reg_wr_en && reg_wr_addr[5:1] == OFS_DAC[5:1])
         begin
            dac_data_ff <= merge_byte(dac_data_ff, reg_wr_addr[0], reg_wr_data, DAC_WMASK);
         end
         if (cmd_ff[CMD_DAC])
         begin
            dac_code_ff <= dac_data_ff[11:0];
         end
         filter_clear_ff <= cmd_ff[CMD_FACTORY] && !nv_busy;
      end
   end

   // ===
   // Flash store and reload sequencer
   always_ff @(posedge clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
      begin
         nv_state_ff <= NV_IDLE;
         nv_idx_ff <= 2'h0;
         wait_cnt_ff <= 24'h000000;
         image_valid_ff <= 1'b0;
         flash_busy_ff <= 1'b0;
         load_vld_ff <= 1'b0;
         load_idx_ff <= 2'h0;
      end
      else
      begin
         load_vld_ff <= (nv_state_ff == NV_LOAD);
         load_idx_ff <= nv_idx_ff;
         case (nv_state_ff)
            NV_IDLE:
            begin
               nv_idx_ff <= 2'h0;
               if (soft_rst && image_valid_ff)
               begin
                  nv_state_ff <= NV_LOAD;
               end
               else if (store_req)
               begin
                  nv_state_ff <= NV_WRITE;
                  flash_busy_ff <= 1'b1;
               end
            end
            NV_WRITE:
            begin
               nv_idx_ff <= nv_idx_ff + 2'h1;
               if (nv_idx_ff == NV_LAST)
               begin
                  image_valid_ff <= 1'b1;
                  wait_cnt_ff <= 24'(FLASH_WAIT - 1);
                  nv_state_ff <= NV_WAIT;
               end
            end
            NV_WAIT:
            begin
               // Flash programming time, busy shown throughout
               wait_cnt_ff <= wait_cnt_ff - 24'h000001;
               if (wait_cnt_ff == 24'h000000)
               begin
                  nv_state_ff <= NV_IDLE;
                  flash_busy_ff <= 1'b0;
               end
            end
            NV_LOAD:
            begin
               nv_idx_ff <= nv_idx_ff + 2'h1;
               if (nv_idx_ff == NV_LAST)
               begin
                  nv_state_ff <= NV_IDLE;
               end
            end
            default:
            begin
               nv_state_ff <= NV_IDLE;
            end
         endcase
      end
   end

   // Image data: the period from before any self-test is stored
   assign mem_wr = (nv_state_ff == NV_WRITE);
   assign mem_wdata = (nv_idx_ff == NV_MSC) ? (misc_control_reg_ff & MSC_WMASK) :
                      (nv_idx_ff == NV_SMPL) ? (self_run_ff ? smpl_saved_ff : smpl_ff) :
                      tilt_offset_reg_ff;

   nv_image_mem u_nv_image_mem
   (
      .clk(clk),
      .wr_en(mem_wr),
      .addr(nv_idx_ff),
      .wr_data(mem_wdata),
      .rd_data(mem_rd)
   );

   // ===
   // Angle outputs: offset, reverse rotation, self-test override
   assign angle_diff = (incl_raw >= tilt_offset_reg_ff[13:0]) ?
                       (incl_raw - tilt_offset_reg_ff[13:0]) :
                       (incl_raw + ANGLE_FULL - tilt_offset_reg_ff[13:0]);
   assign angle_corr = (misc_control_reg_ff[MSC_REV] && angle_diff != 14'h0000) ?
                       (ANGLE_FULL - angle_diff) : angle_diff;
   assign angle_show = self_run_ff ? ANGLE_SELF : angle_corr;

   // Output words with the alarm indicator in bit 14
   always_ff @(posedge clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
      begin
         incl_word_ff <= 16'h0000;
         incl180_word_ff <= 16'h0000;
      end
      else
      begin
         incl_word_ff <= {1'b0, status_ff != RST_STATUS, angle_show};
         incl180_word_ff <= {1'b0, status_ff != RST_STATUS,
                             (angle_show > ANGLE_HALF) ? (angle_show - ANGLE_FULL) :
                             angle_show};
      end
   end

   // ===
   // Data-ready pulse, processing done to midway
   always_ff @(posedge clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
      begin
         dr_active_ff <= 1'b0;
      end
      else if (soft_rst || !misc_control_reg_ff[MSC_DR_EN])
      begin
         dr_active_ff <= 1'b0;
      end
      else if (proc_done)
      begin
         dr_active_ff <= 1'b1;
      end
      else if (conv_midway)
      begin
         dr_active_ff <= 1'b0;
      end
   end
   assign dr_level = dr_active_ff ~^ misc_control_reg_ff[MSC_DR_POL];

   // ===
   // Pin arbitration, one copy per general-purpose pin
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_pin
         always_ff @(posedge clk or negedge rst_s_n)
         begin
            if (!rst_s_n)
            begin
               io_out_ff[gi] <= 1'b0;
               io_oe_ff[gi] <= 1'b0;
            end
            else if (misc_control_reg_ff[MSC_DR_EN] &&
                     misc_control_reg_ff[MSC_DR_SEL] == 1'(gi))
            begin
               io_out_ff[gi] <= dr_level;
               io_oe_ff[gi] <= 1'b1;
            end
            else if (alm_pin_claim[gi])
            begin
               io_out_ff[gi] <= alm_pin_level[gi];
               io_oe_ff[gi] <= 1'b1;
            end
            else
            begin
               io_out_ff[gi] <= gpio_level[gi];
               io_oe_ff[gi] <= gpio_dir[gi];
            end
         end
      end
   endgenerate

   // ===
   // Register read; command and unmapped words read zero
   always_ff @(posedge clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
      begin
         rd_data_ff <= 16'h0000;
      end
      else if (reg_rd_en)
      begin
         if (reg_rd_addr[5:1] == OFS_STATUS[5:1])
         begin
            rd_data_ff <= status_ff;
         end
         else if (reg_rd_addr[5:1] == OFS_MSC[5:1])
         begin
            rd_data_ff <= misc_control_reg_ff;
         end
         else if (reg_rd_addr[5:1] == OFS_SMPL[5:1])
         begin
            rd_data_ff <= smpl_ff;
         end
         else if (reg_rd_addr[5:1] == OFS_OFFSET[5:1])
         begin
            rd_data_ff <= tilt_offset_reg_ff;
         end
         else if (reg_rd_addr[5:1] == OFS_DAC[5:1])
         begin
            rd_data_ff <= dac_data_ff;
         end
         else
         begin
            rd_data_ff <= 16'h0000;
         end
      end
   end

   // Output connections, all from flip-flops
   assign reg_rd_data = rd_data_ff;
   assign incl_word = incl_word_ff;
   assign incl180_word = incl180_word_ff;
   assign sample_period_reg = smpl_ff;
   assign dac_code = dac_code_ff;
   assign filter_clear = filter_clear_ff;
   assign flash_busy = flash_busy_ff;
   assign io_line_first_out = io_out_ff[0];
   assign io_line_first_oe = io_oe_ff[0];
   assign io_line_second_out = io_out_ff[1];
   assign io_line_second_oe = io_oe_ff[1];
endmodule

/* File: testbench/scmc_sva.sv */
// Checker for the status, command and misc-control block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module scmc_sva
   import scmc_pkg::*;
(
   // Clock, reset and register port
   input wire logic clk,
   input wire logic rst_n,
   input wire logic reg_wr_en,
   input wire logic [5:0] reg_wr_addr,
   input wire logic [7:0] reg_wr_data,
   input wire logic reg_rd_en,
   input wire logic [5:0] reg_rd_addr,
   input wire logic [15:0] reg_rd_data,
   // Observed side
   input wire logic supply_low,
   input wire logic [15:0] incl_word,
   input wire logic [15:0] incl180_word,
   input wire logic [11:0] dac_code,
   input wire logic filter_clear,
   input wire logic flash_busy
);
   // ===
   // Assertions
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Latch command seen on the port
   wire logic lat = reg_wr_en && reg_wr_addr == OFS_CMD && reg_wr_data[CMD_DAC];
   word_format_a: assert property (!incl_word[15] && !incl180_word[15] &&
      incl180_word[14] == incl_word[14] && incl180_word[13:0] ==
      ((incl_word[13:0] > ANGLE_HALF) ? incl_word[13:0] - ANGLE_FULL : incl_word[13:0]))
      else $error("output word format wrong");
   alarm_match_a: assert property (reg_rd_en && reg_rd_addr == OFS_STATUS |=>
      (reg_rd_data != 16'h0000) == incl_word[14])
      else $error("alarm bit disagrees with status");
   clear_pulse_a: assert property (filter_clear |=> !filter_clear)
      else $error("filter clear too long");
   factory_store_a: assert property (filter_clear |-> ##[0:4] flash_busy)
      else $error("no store after factory reset");
   busy_span_a: assert property ($rose(flash_busy) |-> flash_busy[*8])
      else $error("store too short");
   dac_latch_a: assert property ($changed(dac_code) |-> $past(lat) || $past(lat, 2))
      else $error("dac moved without latch");
   cmd_read_a: assert property (reg_rd_en && reg_rd_addr == OFS_CMD |=> reg_rd_data == 16'h0000)
      else $error("command word read back");
   sup_alarm_a: assert property (supply_low [*3] |-> incl_word[14])
      else $error("supply alarm missing");
   // Main scenarios reached
   factory_c: cover property (filter_clear);
   latch_c: cover property ($changed(dac_code));
   busy_c: cover property ($rose(flash_busy));
endmodule
bind status_command_misc_control scmc_sva chk (.clk, .rst_n,
   .reg_wr_en, .reg_wr_addr, .reg_wr_data, .reg_rd_en, .reg_rd_addr, .reg_rd_data,
   .supply_low, .incl_word, .incl180_word, .dac_code, .filter_clear, .flash_busy);

/* File: testbench/host_model.sv */
// Host model: byte writes and word reads on the register port.
// Assumes the block samples on rising edges; drives on falling edges.
`timescale 1ns/100ps
module host_model
(
   // Clock and register port
   input wire logic clk,
   output logic reg_wr_en,
   output logic [5:0] reg_wr_addr,
   output logic [7:0] reg_wr_data,
   output logic reg_rd_en,
   output logic [5:0] reg_rd_addr,
   input wire logic [15:0] reg_rd_data
);
   // ===
   // Idle port from time zero
   initial
      {reg_wr_en, reg_wr_addr, reg_wr_data, reg_rd_en, reg_rd_addr} = 22'h000000;
   // One byte write, strobe held across one rising edge
   task automatic w(input logic [5:0] a, input logic [7:0] d);
      @(negedge clk);
      {reg_wr_en, reg_wr_addr, reg_wr_data} = {1'b1, a, d};
      @(negedge clk);
      {reg_wr_en, reg_wr_data} = {1'b0, ~d};
   endtask
   // Word read, data taken the cycle after
   task automatic r(input logic [5:0] a, output logic [15:0] d);
      @(negedge clk);
      {reg_rd_en, reg_rd_addr} = {1'b1, a};
      @(negedge clk);
      reg_rd_en = 1'b0;
      d = reg_rd_data;
   endtask
endmodule

/* File: testbench/status_command_misc_control_tb.sv */
// Testbench for the status, command and misc-control block.
// Assumes the host model drives the register port.
`timescale 1ns/100ps
module status_command_misc_control_tb;
   import scmc_pkg::*;
   // ===
   // Signals
   logic clk, rst_n, supply_low, supply_high, spi_fail, alarm1_active, alarm2_active;
   logic self_check_fail, proc_done, conv_midway, filter_clear, flash_busy;
   logic reg_wr_en, reg_rd_en, io_line_first_out, io_line_first_oe;
   logic io_line_second_out, io_line_second_oe;
   logic [1:0] alm_pin_claim, alm_pin_level, gpio_dir, gpio_level;
   logic [5:0] reg_wr_addr, reg_rd_addr;
   logic [7:0] reg_wr_data;
   logic [13:0] incl_raw;
   logic [11:0] dac_code;
   logic [15:0] reg_rd_data, incl_word, incl180_word, sample_period_reg, d;
   int n_mismatch = 0, comparisons = 0;
   host_model h (.clk, .reg_wr_en, .reg_wr_addr, .reg_wr_data, .reg_rd_en, .reg_rd_addr,
      .reg_rd_data);
   status_command_misc_control #(.FLASH_WAIT(20)) DUT (.clk, .rst_n, .reg_wr_en,
      .reg_wr_addr, .reg_wr_data, .reg_rd_en, .reg_rd_addr, .reg_rd_data, .supply_low,
      .supply_high, .spi_fail, .alarm1_active, .alarm2_active, .self_check_fail,
      .proc_done, .conv_midway, .incl_raw, .incl_word, .incl180_word, .sample_period_reg,
      .dac_code, .filter_clear, .flash_busy, .alm_pin_claim, .alm_pin_level, .gpio_dir,
      .gpio_level, .io_line_first_out, .io_line_first_oe, .io_line_second_out,
      .io_line_second_oe);
   // ===
   // Helpers
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic ck(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("wrong value t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // One-cycle timing pulse, then settle
   task automatic ev(input logic m);
      {proc_done, conv_midway} = {m, !m};
      cyc(1);
      {proc_done, conv_midway} = 2'b00;
      cyc(2);
   endtask
   // Wait out a store under a bound
   task automatic idle;
      int i;
      for (i = 0; i < 200 && flash_busy !== 1'b0; i++)
         cyc(1);
      ck({15'h0000, flash_busy}, 16'h0000);
   endtask
   task automatic give_verdict;
      $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ===
   // Scenarios
   task automatic t_regs;
      h.w(OFS_STATUS, 8'hFF);
      h.r(OFS_STATUS, d);
      ck(d, RST_STATUS);
      h.w(OFS_MSC, 8'h06);
      h.w(OFS_CMD, 8'h80);
      cyc(4);
      h.r(OFS_MSC, d);
      ck(d, RST_MSC);
      h.r(OFS_CMD, d);
      ck(d, 16'h0000);
   endtask
   task automatic t_flags;
      supply_low = 1'b1;
      h.w(OFS_CMD, 8'h10);
      cyc(2);
      h.r(OFS_STATUS, d);
      ck(d, 16'h0001);
      {supply_low, supply_high} = 2'b01;
      cyc(2);
      h.r(OFS_STATUS, d);
      ck(d, 16'h0002);
      {supply_high, spi_fail, alarm1_active, alarm2_active} = 4'h7;
      cyc(1);
      {spi_fail, alarm1_active, alarm2_active} = 3'b000;
      h.w(OFS_CMD, 8'h00);
      h.r(OFS_STATUS, d);
      ck(d, 16'h0308);
      h.w(OFS_CMD, 8'h10);
      cyc(2);
      h.r(OFS_STATUS, d);
      ck(d, 16'h0000);
   endtask
   task automatic t_dac;
      h.w(OFS_DAC, 8'h34);
      h.w(OFS_DAC + 6'h01, 8'h02);
      ck({4'h0, dac_code}, 16'h0000);
      h.w(OFS_CMD, 8'h04);
      cyc(2);
      ck({4'h0, dac_code}, 16'h0234);
   endtask
   task automatic t_pins;
      {alm_pin_claim, gpio_dir, gpio_level} = 6'h3F;
      h.w(OFS_MSC, 8'h06);
      ev(1'b1);
      ck({13'h0000, io_line_first_oe, io_line_first_out, io_line_second_out}, 16'h0006);
      ev(1'b0);
      ck({15'h0000, io_line_first_out}, 16'h0000);
      h.w(OFS_MSC, 8'h05);
      ev(1'b0);
      ck({15'h0000, io_line_second_out}, 16'h0001);
      alm_pin_claim = 2'b00;
      cyc(2);
      ck({13'h0000, io_line_first_oe, io_line_first_out, io_line_second_oe}, 16'h0007);
   endtask
   task automatic t_self;
      {incl_raw, self_check_fail} = {14'h0064, 1'b1};
      h.w(OFS_MSC + 6'h01, 8'h01);
      cyc(2);
      ck(sample_period_reg, SMPL_FAST);
      ck(incl_word & 16'h3FFF, {2'h0, ANGLE_SELF});
      h.w(OFS_MSC + 6'h01, 8'h02);
      cyc(2);
      self_check_fail = 1'b0;
      ck(sample_period_reg, RST_SMPL);
      ck({2'b00, incl_word[13:0]}, 16'h37DC);
      h.r(OFS_STATUS, d);
      ck(d & 16'h0020, 16'h0020);
      h.w(OFS_MSC + 6'h01, 8'h00);
      h.w(OFS_CMD, 8'h10);
   endtask
   task automatic t_store;
      h.w(OFS_OFFSET, 8'h12);
      h.w(OFS_CMD, 8'h02);
      h.w(OFS_OFFSET, 8'h34);
      idle();
      h.r(OFS_OFFSET, d);
      ck(d, RST_OFFSET);
      h.r(OFS_STATUS, d);
      ck(d, 16'h0004);
      h.w(OFS_CMD, 8'h01);
      cyc(3);
      idle();
      ck({incl_word[13:0], incl180_word[1:0]}, 16'h0000);
      h.w(OFS_CMD, 8'h08);
      cyc(3);
      ck({15'h0000, flash_busy}, 16'h0001);
      idle();
      h.w(OFS_CMD, 8'h80);
      cyc(6);
      h.r(OFS_OFFSET, d);
      ck(d, 16'h0064);
   endtask
   // ===
   // Clock, reset, sequence and watchdog
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial
   begin
      {rst_n, supply_low, supply_high, spi_fail, alarm1_active, alarm2_active} = 6'h00;
      {self_check_fail, proc_done, conv_midway, incl_raw} = 17'h00000;
      {alm_pin_claim, alm_pin_level, gpio_dir, gpio_level} = 8'h00;
      cyc(12);
      rst_n = 1'b1;
      cyc(3);
      t_regs();
      t_flags();
      t_dac();
      t_pins();
      t_self();
      t_store();
      give_verdict();
   end
   initial
   begin
      #25000;
      n_mismatch++;
      give_verdict();
   end
endmodule
